// ==== core/arfm_params.svh ====
`ifndef ARFM_PARAMS_SVH
`define ARFM_PARAMS_SVH

// Register indices; byte address is four times the index
`define ARFM_IDX_STATUS 8'h01
`define ARFM_IDX_SAMPLE 8'h02
`define ARFM_IDX_CONV 8'h03
`define ARFM_IDX_INTST 8'h10
`define ARFM_IDX_INTMSK 8'h11
`define ARFM_IDX_CTRL 8'h12
`define ARFM_IDX_RUN 8'h13

// Reset values
`define ARFM_STATUS_RST 8'h01
`define ARFM_SAMPLE_RST 8'h24
`define ARFM_CONV_RST 8'h01
`define ARFM_INT_RST 2'h0

// Field positions
`define ARFM_RESET_FLAG_BIT 0
`define ARFM_RATE_LSB 3
`define ARFM_FILT_LSB 0
`define ARFM_CHOP_BIT 5
`define ARFM_ONESHOT_BIT 4
`define ARFM_DELAY_LSB 0
`define ARFM_CTRL_START_BIT 0
`define ARFM_CTRL_STOP_BIT 1
`define ARFM_INT_DRDY_BIT 0
`define ARFM_INT_CFGERR_BIT 1

// Code limits
`define ARFM_FILT_MAX 3'h4
`define ARFM_DELAY_MAX 4'hD
`define ARFM_DELAY_NONE 4'h0
`define ARFM_RATE_25600 5'h0F

// Clock and time units
`define ARFM_CLK_HZ 100000000
`define ARFM_US_PER_S 1000000
`define ARFM_DSPS_PER_SPS 10

// Output data rates in tenths of samples per second
`define ARFM_DSPS_00 25
`define ARFM_DSPS_01 50
`define ARFM_DSPS_02 100
`define ARFM_DSPS_03 166
`define ARFM_DSPS_04 200
`define ARFM_DSPS_05 500
`define ARFM_DSPS_06 600
`define ARFM_DSPS_07 1000
`define ARFM_DSPS_08 4000
`define ARFM_DSPS_09 12000
`define ARFM_DSPS_0A 24000
`define ARFM_DSPS_0B 48000
`define ARFM_DSPS_0C 72000
`define ARFM_DSPS_0D 144000
`define ARFM_DSPS_0E 192000
`define ARFM_DSPS_0F 256000
`define ARFM_DSPS_HI 400000

// Start-of-conversion delays in microseconds
`define ARFM_DLY_US_1 50
`define ARFM_DLY_US_2 59
`define ARFM_DLY_US_3 67
`define ARFM_DLY_US_4 85
`define ARFM_DLY_US_5 119
`define ARFM_DLY_US_6 189
`define ARFM_DLY_US_7 328
`define ARFM_DLY_US_8 605
`define ARFM_DLY_US_9 1160
`define ARFM_DLY_US_A 2270
`define ARFM_DLY_US_B 4490
`define ARFM_DLY_US_C 8930
`define ARFM_DLY_US_D 17800

`endif

// ==== core/arfm_pkg.sv ====
`default_nettype none

package arfm_pkg;

  typedef enum logic [1:0] {
    ARFM_IDLE,
    ARFM_DELAY,
    ARFM_CONVERT
  } arfm_state_t;

  typedef struct packed {
    logic [4:0] rate_selector;
    logic [2:0] filter_select;
    logic offset_chop_enable;
    logic one_shot_select;
    logic [3:0] start_delay;
  } arfm_cfg_t;

  typedef struct packed {
    logic busy;
    logic converting;
    logic data_ready;
  } arfm_run_t;

endpackage

`default_nettype wire

// ==== core/arfm_delay_timer.sv ====
`default_nettype none

module arfm_delay_timer #(
  parameter int WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic abort,
  input wire logic [WIDTH-1:0] count,
  output logic done_q,
  output logic busy_q
);

  logic [WIDTH-1:0] cnt_q;

  generate
    if (WIDTH < 2) begin : g_bad
      $error("arfm_delay_timer: WIDTH too small");
    end
  endgenerate

  // A zero count would never finish, so it runs one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (abort) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (load) begin
      cnt_q <= (count == '0) ? WIDTH'(1) : count;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - WIDTH'(1);
      if (cnt_q == WIDTH'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && !abort && !load && (cnt_q == WIDTH'(1));
    end
  end

endmodule

`default_nettype wire

// ==== core/arfm_top.sv ====
// Decided for this implementation: the APB interface to the registers.
`include "arfm_params.svh"
`default_nettype none

module arfm_top #(
  parameter int CLK_HZ = `ARFM_CLK_HZ,
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_q,
  output var arfm_pkg::arfm_cfg_t cfg_q,
  output var arfm_pkg::arfm_run_t run_q
);

  generate
    if (CLK_HZ < `ARFM_US_PER_S) begin : g_bad_clk
      $error("arfm_top: CLK_HZ below 1 MHz");
    end
    if (ADDR_W < 11) begin : g_bad_addr
      $error("arfm_top: ADDR_W too small for the map");
    end
  endgenerate

  logic [7:0] status_q;
  logic [7:0] sample_q;
  logic [7:0] conv_q;
  logic [1:0] int_st_q;
  logic [1:0] int_mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  arfm_pkg::arfm_state_t state_q;
  logic tmr_load;
  logic tmr_abort;
  logic [31:0] tmr_count;
  logic tmr_done;
  logic tmr_busy;
  logic [7:0] idx;
  logic mapped;
  logic setup;
  logic wr_acc;
  logic wr_sample;
  logic wr_conv;
  logic wr_status;
  logic wr_intst;
  logic wr_intmsk;
  logic wr_ctrl;
  logic start_req;
  logic stop_req;
  logic restart;
  logic cfg_err;
  logic drdy_ev;
  logic [7:0] sample_d;
  logic [7:0] conv_d;

  // Period of one conversion in clock cycles for a rate code
  function automatic logic [31:0] rate_cycles(input logic [4:0] code);
    longint dsps;
    dsps = `ARFM_DSPS_HI;
    case (code)
      5'h00: dsps = `ARFM_DSPS_00;
      5'h01: dsps = `ARFM_DSPS_01;
      5'h02: dsps = `ARFM_DSPS_02;
      5'h03: dsps = `ARFM_DSPS_03;
      5'h04: dsps = `ARFM_DSPS_04;
      5'h05: dsps = `ARFM_DSPS_05;
      5'h06: dsps = `ARFM_DSPS_06;
      5'h07: dsps = `ARFM_DSPS_07;
      5'h08: dsps = `ARFM_DSPS_08;
      5'h09: dsps = `ARFM_DSPS_09;
      5'h0A: dsps = `ARFM_DSPS_0A;
      5'h0B: dsps = `ARFM_DSPS_0B;
      5'h0C: dsps = `ARFM_DSPS_0C;
      5'h0D: dsps = `ARFM_DSPS_0D;
      5'h0E: dsps = `ARFM_DSPS_0E;
      5'h0F: dsps = `ARFM_DSPS_0F;
      default: dsps = `ARFM_DSPS_HI;
    endcase
    // Upper codes all share the top rate
    return 32'((longint'(CLK_HZ) * `ARFM_DSPS_PER_SPS) / dsps);
  endfunction

  // Start delay in clock cycles, rounded up as a least time
  function automatic logic [31:0] delay_cycles(input logic [3:0] code);
    longint us;
    us = 0;
    case (code)
      4'h1: us = `ARFM_DLY_US_1;
      4'h2: us = `ARFM_DLY_US_2;
      4'h3: us = `ARFM_DLY_US_3;
      4'h4: us = `ARFM_DLY_US_4;
      4'h5: us = `ARFM_DLY_US_5;
      4'h6: us = `ARFM_DLY_US_6;
      4'h7: us = `ARFM_DLY_US_7;
      4'h8: us = `ARFM_DLY_US_8;
      4'h9: us = `ARFM_DLY_US_9;
      4'hA: us = `ARFM_DLY_US_A;
      4'hB: us = `ARFM_DLY_US_B;
      4'hC: us = `ARFM_DLY_US_C;
      4'hD: us = `ARFM_DLY_US_D;
      default: us = 0;
    endcase
    return 32'((us * CLK_HZ + `ARFM_US_PER_S - 1) / `ARFM_US_PER_S);
  endfunction

  // Checks a pair of configuration bytes against the reserved codes
  function automatic logic bad_cfg(input logic [7:0] smp, input logic [7:0] cnv);
    logic [4:0] rate;
    logic [2:0] filt;
    logic [3:0] dly;
    rate = smp[`ARFM_RATE_LSB +: 5];
    filt = smp[`ARFM_FILT_LSB +: 3];
    dly = cnv[`ARFM_DELAY_LSB +: 4];
    return (filt > `ARFM_FILT_MAX)
      || (dly > `ARFM_DELAY_MAX)
      || ((dly == `ARFM_DELAY_NONE) && (rate >= `ARFM_RATE_25600));
  endfunction

  // Bus decode
  assign idx = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0) &&
    ((idx == `ARFM_IDX_STATUS) || (idx == `ARFM_IDX_SAMPLE) ||
     (idx == `ARFM_IDX_CONV) || (idx == `ARFM_IDX_INTST) ||
     (idx == `ARFM_IDX_INTMSK) || (idx == `ARFM_IDX_CTRL) ||
     (idx == `ARFM_IDX_RUN));
  assign setup = psel && !penable;
  // Writes land only at the completing access edge
  assign wr_acc = psel && penable && pready_q && pwrite && mapped && pstrb[0];
  assign wr_status = wr_acc && (idx == `ARFM_IDX_STATUS);
  assign wr_sample = wr_acc && (idx == `ARFM_IDX_SAMPLE);
  assign wr_conv = wr_acc && (idx == `ARFM_IDX_CONV);
  assign wr_intst = wr_acc && (idx == `ARFM_IDX_INTST);
  assign wr_intmsk = wr_acc && (idx == `ARFM_IDX_INTMSK);
  assign wr_ctrl = wr_acc && (idx == `ARFM_IDX_CTRL);
  assign start_req = wr_ctrl && pwdata[`ARFM_CTRL_START_BIT];
  assign stop_req = wr_ctrl && pwdata[`ARFM_CTRL_STOP_BIT];
  assign sample_d = wr_sample ? pwdata[7:0] : sample_q;
  assign conv_d = wr_conv ? pwdata[7:0] : conv_q;
  // A new setting abandons the conversion in flight
  assign restart = (wr_sample || wr_conv) && (state_q != arfm_pkg::ARFM_IDLE);
  assign cfg_err = (wr_sample || wr_conv) && bad_cfg(sample_d, conv_d);
  assign drdy_ev = tmr_done && (state_q == arfm_pkg::ARFM_CONVERT);

  // APB answer: no wait state, data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup && !pwrite && mapped) begin
      case (idx)
        `ARFM_IDX_STATUS: prdata_q <= {24'h0, status_q};
        `ARFM_IDX_SAMPLE: prdata_q <= {24'h0, sample_q};
        `ARFM_IDX_CONV: prdata_q <= {24'h0, conv_q};
        `ARFM_IDX_INTST: prdata_q <= {30'h0, int_st_q};
        `ARFM_IDX_INTMSK: prdata_q <= {30'h0, int_mask_q};
        `ARFM_IDX_RUN: prdata_q <= {29'h0, run_q};
        default: prdata_q <= 32'h0;
      endcase
    end else if (setup) begin
      prdata_q <= 32'h0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Reset-occurred flag: only a reset sets it, a written zero clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `ARFM_STATUS_RST;
    end else if (wr_status && !pwdata[`ARFM_RESET_FLAG_BIT]) begin
      status_q[`ARFM_RESET_FLAG_BIT] <= 1'b0;
    end
  end

  // Sample configuration: rate and filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= `ARFM_SAMPLE_RST;
    end else if (wr_sample) begin
      sample_q <= pwdata[7:0];
    end
  end

  // Conversion mode; reserved bits are stored as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= `ARFM_CONV_RST;
    end else if (wr_conv) begin
      conv_q <= pwdata[7:0];
    end
  end

  // Decoded settings presented to the converter core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q.rate_selector <= sample_q[`ARFM_RATE_LSB +: 5];
      cfg_q.filter_select <= sample_q[`ARFM_FILT_LSB +: 3];
      cfg_q.offset_chop_enable <= conv_q[`ARFM_CHOP_BIT];
      cfg_q.one_shot_select <= conv_q[`ARFM_ONESHOT_BIT];
      cfg_q.start_delay <= conv_q[`ARFM_DELAY_LSB +: 4];
    end
  end

  // Sequencer: optional start delay, then one conversion period, or repeated periods in continuous mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= arfm_pkg::ARFM_IDLE;
    end else if (stop_req) begin
      state_q <= arfm_pkg::ARFM_IDLE;
    end else begin
      case (state_q)
        arfm_pkg::ARFM_IDLE: begin
          if (start_req) begin
            state_q <= (conv_d[`ARFM_DELAY_LSB +: 4] == `ARFM_DELAY_NONE) ?
              arfm_pkg::ARFM_CONVERT : arfm_pkg::ARFM_DELAY;
          end
        end
        arfm_pkg::ARFM_DELAY: begin
          if (restart) begin
            state_q <= (conv_d[`ARFM_DELAY_LSB +: 4] == `ARFM_DELAY_NONE) ?
              arfm_pkg::ARFM_CONVERT : arfm_pkg::ARFM_DELAY;
          end else if (tmr_done) begin
            state_q <= arfm_pkg::ARFM_CONVERT;
          end
        end
        arfm_pkg::ARFM_CONVERT: begin
          if (restart) begin
            state_q <= (conv_d[`ARFM_DELAY_LSB +: 4] == `ARFM_DELAY_NONE) ?
              arfm_pkg::ARFM_CONVERT : arfm_pkg::ARFM_DELAY;
          end else if (tmr_done && conv_q[`ARFM_ONESHOT_BIT]) begin
            state_q <= arfm_pkg::ARFM_IDLE;
          end
        end
        default: state_q <= arfm_pkg::ARFM_IDLE;
      endcase
    end
  end

  // Timer loads: delay on entry, period on each conversion
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = 32'h0;
    if ((state_q == arfm_pkg::ARFM_IDLE && start_req) || restart) begin
      tmr_load = 1'b1;
      if (conv_d[`ARFM_DELAY_LSB +: 4] == `ARFM_DELAY_NONE) begin
        tmr_count = rate_cycles(sample_d[`ARFM_RATE_LSB +: 5]);
      end else begin
        tmr_count = delay_cycles(conv_d[`ARFM_DELAY_LSB +: 4]);
      end
    end else if (tmr_done && state_q == arfm_pkg::ARFM_DELAY) begin
      tmr_load = 1'b1;
      tmr_count = rate_cycles(sample_q[`ARFM_RATE_LSB +: 5]);
    end else if (drdy_ev && !conv_q[`ARFM_ONESHOT_BIT]) begin
      // Continuous mode chains periods with no further delay
      tmr_load = 1'b1;
      tmr_count = rate_cycles(sample_q[`ARFM_RATE_LSB +: 5]);
    end
    // Auto-zero takes a second phase, so the period doubles but a delay does not
    if (conv_d[`ARFM_CHOP_BIT] && tmr_load &&
        !(((state_q == arfm_pkg::ARFM_IDLE && start_req) || restart) &&
          (conv_d[`ARFM_DELAY_LSB +: 4] != `ARFM_DELAY_NONE))) begin
      tmr_count = {tmr_count[30:0], 1'b0};
    end
  end

  assign tmr_abort = stop_req;

  arfm_delay_timer #(
    .WIDTH(32)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .abort(tmr_abort),
    .count(tmr_count),
    .done_q(tmr_done),
    .busy_q(tmr_busy)
  );

  // Run status seen by software and the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
    end else begin
      run_q.busy <= (state_q != arfm_pkg::ARFM_IDLE);
      run_q.converting <= (state_q == arfm_pkg::ARFM_CONVERT) && tmr_busy;
      run_q.data_ready <= drdy_ev;
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st_q <= `ARFM_INT_RST;
    end else begin
      if (wr_intst) begin
        int_st_q <= int_st_q & ~pwdata[1:0];
      end
      if (drdy_ev) begin
        int_st_q[`ARFM_INT_DRDY_BIT] <= 1'b1;
      end
      if (cfg_err) begin
        int_st_q[`ARFM_INT_CFGERR_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_q <= `ARFM_INT_RST;
    end else if (wr_intmsk) begin
      int_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_st_q & int_mask_q);
    end
  end

endmodule

`default_nettype wire

// ==== sim/arfm_host.sv ====
`default_nettype none

module arfm_host (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // Idle cycle at the end keeps strobes single-driven per step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
    logic [31:0] v;
    v = d;
    if (w && a == 12'h00C) begin
      v[7:6] = 2'h0;
      if (v[3:0] > 4'hD) v[3:0] = 4'hD;
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

`default_nettype wire

// ==== sim/arfm_top_monitor.sv ====
`default_nettype none

module arfm_top_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_q,
  input wire arfm_pkg::arfm_cfg_t cfg_q,
  input wire arfm_pkg::arfm_run_t run_q
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [ADDR_W-1:0] SAMPLE_A = 8;
  localparam logic [ADDR_W-1:0] CONV_A = 12;
  logic wr;
  assign wr = psel && penable && pwrite && pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_answer: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_idle: assert property (!psel |=> !pready) else $error("ready while idle");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_sample_read: assert property (pready && !pwrite && paddr == SAMPLE_A
    |-> prdata[7:0] == {cfg_q.rate_selector, cfg_q.filter_select}) else $error("sample");
  a_conv_read: assert property (pready && !pwrite && paddr == CONV_A
    |-> prdata[5:0] == {cfg_q.offset_chop_enable, cfg_q.one_shot_select, cfg_q.start_delay})
    else $error("conv mismatch");
  a_cfg_default: assert property ($rose(presetn) |=> cfg_q == 14'h0901)
    else $error("cfg default");
  a_cfg_hold: assert property (!$stable(cfg_q) |-> $past(wr, 2) || !$past(presetn, 2))
    else $error("cfg changed without write");
  a_drdy_pulse: assert property (run_q.data_ready |=> !run_q.data_ready)
    else $error("data ready too long");
  a_irq_fall: assert property ($fell(irq_q) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3))
    else $error("irq fell without write");
endmodule

bind arfm_top arfm_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_q(irq_q),
  .cfg_q(cfg_q), .run_q(run_q));

`default_nettype wire

// ==== sim/tb.sv ====
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, irq_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  arfm_pkg::arfm_cfg_t cfg_q;
  arfm_pkg::arfm_run_t run_q;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  localparam logic [4:0] RATES [5] = '{5'h00, 5'h04, 5'h0F, 5'h10, 5'h1F};
  localparam logic [7:0] CONVS [4] = '{8'h00, 8'h21, 8'h12, 8'hFF};

  // Short clock rate keeps delay and period counts small
  arfm_top #(.CLK_HZ(1000000), .ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_q(irq_q),
    .cfg_q(cfg_q), .run_q(run_q));
  arfm_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, 4'hF, r, e);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0, 4'hF, r, e);
    check(nm, r, exp);
  endtask

  task automatic t_reset;
    rdc("status", 12'h004, 32'h01);
    rdc("sample", 12'h008, 32'h24);
    rdc("conv", 12'h00C, 32'h01);
    rdc("int_status", 12'h040, 32'h0);
    rdc("int_mask", 12'h044, 32'h0);
    check("cfg", {18'h0, cfg_q}, 32'h901);
    check("irq", {31'h0, irq_q}, 32'h0);
  endtask

  task automatic t_sample;
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      v = {RATES[i], 3'(i)};
      wr(12'h008, {24'h0, v});
      rdc("sample", 12'h008, {24'h0, v});
      check("cfg", {18'h0, cfg_q}, {18'h0, v, 6'h01});
    end
  endtask

  task automatic t_conv;
    logic [7:0] e;
    wr(12'h008, 32'h24);
    for (int i = 0; i < 4; i++) begin
      e = CONVS[i] & 8'h3F;
      if (e[3:0] > 4'hD) e[3:0] = 4'hD;
      wr(12'h00C, {24'h0, CONVS[i]});
      rdc("conv", 12'h00C, {24'h0, e});
      check("cfg", {18'h0, cfg_q}, {18'h0, 8'h24, e[5:0]});
    end
  endtask

  task automatic t_err;
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, 12'h3F0, 32'h0, 4'hF, r, e);
    check("unmapped", {e, r[30:0]}, 32'h80000000);
    host.xfer(1'b0, 12'h009, 32'h0, 4'hF, r, e);
    check("misaligned", {31'h0, e}, 32'h1);
    host.xfer(1'b1, 12'h008, 32'h0, 4'hE, r, e);
    rdc("strobe_off", 12'h008, 32'h24);
  endtask

  task automatic measure(input logic [7:0] s, input logic [7:0] c, output int n);
    repeat (4) @(posedge pclk);
    wr(12'h008, {24'h0, s});
    wr(12'h00C, {24'h0, c});
    wr(12'h048, 32'h1);
    n = 0;
    while (run_q.data_ready !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic t_rate;
    int n1, n2, n3, n4, n5, n6;
    measure(8'h84, 8'h11, n1);
    measure(8'hFC, 8'h11, n2);
    measure(8'h7C, 8'h11, n3);
    measure(8'h84, 8'h31, n4);
    measure(8'h84, 8'h12, n5);
    measure(8'h74, 8'h10, n6);
    check("top_codes", 32'(n2 == n1), 32'h1);
    check("ascending", 32'(n3 > n1), 32'h1);
    check("auto_zero", 32'(n4 - n1), 32'h19);
    check("delay_step", 32'(n5 - n1), 32'h9);
    check("no_delay", 32'(n6), 32'h35);
    repeat (5) @(posedge pclk);
    check("one_shot", {31'h0, run_q.busy}, 32'h0);
    measure(8'h84, 8'h01, n1);
    repeat (5) @(posedge pclk);
    check("continuous", {31'h0, run_q.busy}, 32'h1);
    check("converting", {31'h0, run_q.converting}, 32'h1);
    rdc("run_status", 12'h04C, 32'h6);
    wr(12'h048, 32'h2);
    repeat (3) @(posedge pclk);
    check("stopped", {31'h0, run_q.busy}, 32'h0);
  endtask

  task automatic t_irq;
    int n;
    wr(12'h040, 32'h3);
    wr(12'h044, 32'h1);
    repeat (3) @(posedge pclk);
    check("irq_idle", {31'h0, irq_q}, 32'h0);
    measure(8'h84, 8'h11, n);
    repeat (3) @(posedge pclk);
    check("irq_set", {31'h0, irq_q}, 32'h1);
    rdc("int_status", 12'h040, 32'h1);
    wr(12'h040, 32'h1);
    repeat (3) @(posedge pclk);
    check("irq_clear", {31'h0, irq_q}, 32'h0);
    wr(12'h044, 32'h0);
    measure(8'h84, 8'h11, n);
    repeat (3) @(posedge pclk);
    check("irq_masked", {31'h0, irq_q}, 32'h0);
    rdc("int_pending", 12'h040, 32'h1);
    wr(12'h040, 32'h1);
    wr(12'h008, 32'h85);
    rdc("cfg_error", 12'h040, 32'h2);
    wr(12'h040, 32'h2);
  endtask

  // Second reset must bring the flag and defaults back
  task automatic t_flag;
    wr(12'h008, 32'hFC);
    wr(12'h004, 32'h0);
    rdc("flag_clear", 12'h004, 32'h0);
    wr(12'h004, 32'h1);
    rdc("flag_stays", 12'h004, 32'h0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset;
  endtask

  initial begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_sample;
    t_conv;
    t_err;
    t_rate;
    t_irq;
    t_flag;
    end_of_test;
  end
endmodule

`default_nettype wire
